//--- hdl/asr_receiver.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "asr_params.svh"

// ----------------------------------------
// Asynchronous serial receiver
// ----------------------------------------
// How it works
// - Falling line edge while idle starts a character; start bit must be low
// - Half bit later line is rechecked; high means silent abort and rehunt
// - Each later bit sampled one bit period on, majority voted, shifted in
// - Stop bit sampled after last data bit; low sets that character's framing error
// - Finished character moves into the FIFO and raises the ready flag
// - Reading the data register returns the oldest character and removes it
// - Ready flag is high exactly while unread characters exist; writes ignored
// - Ready follows occupancy; interrupt needs receive, peripheral and global enables
// - Every FIFO entry keeps its own framing error; flag shows the oldest
// - Framing errors never stop reception; next read shows next status
// - Port enable low resets the port and clears framing error; receive enable doesn't
// - Framing error alone never raises an interrupt
// - Third whole character arriving with two unread sets overrun
// - During overrun stored characters stay readable, nothing new is accepted
// - Overrun clears when receive enable or port enable is cleared
// - Nine-bit mode shifts nine bits; ninth bit flag shows oldest character's
// - Address detect stores and flags only characters with ninth bit set
// - In address detect every stored character has ninth bit one
// - Line is sampled on a sixteen-times-baud tick; shifter moves once per bit
// - Port enable forces the receive pin to be an input
module asr_receiver
    import asr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic receive_line_pin,
    output logic receive_pin_input,
    output logic receive_ready_flag,
    output logic rx_irq
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] baud_q;
    logic [7:0] div_q;
    logic tick_q;
    logic rx_m_q;
    logic rx_s;
    logic rx_d_q;
    logic rx_fall;
    logic vote;
    asr_state_e st_q;
    logic [3:0] cnt_q;
    logic [3:0] bit_q;
    logic [8:0] sr_q;
    asr_entry_s mem_q [`ASR_FIFO_DEPTH];
    asr_entry_s head;
    asr_entry_s in_entry;
    logic rd_ptr_q;
    logic wr_ptr_q;
    logic [1:0] count_q;
    logic [1:0] count_d;
    logic ovr_q;
    logic pop_ok_q;
    logic port_en;
    logic rx_run;
    logic nine;
    logic addr_det;
    logic irq_en;
    logic acc;
    logic xfer;
    logic pop;
    logic char_done;
    logic keep;
    logic full;
    logic push;
    logic ovr_set;
    logic framing_error_flag_flag;
    logic [3:0] last_bit;
    logic [31:0] rd_d;

    // Register address decode for the error answer; the read mux compares addresses itself
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `ASR_OFF_CTRL) || (a == `ASR_OFF_STAT)
                 || (a == `ASR_OFF_DATA) || (a == `ASR_OFF_BAUD);
    endfunction

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    assign port_en = ctrl_q[`ASR_CT_PORT_EN];
    assign rx_run = port_en && ctrl_q[`ASR_CT_CONTINUOUS_RECEIVE_ENABLE];
    assign nine = ctrl_q[`ASR_CT_NINE];
    assign addr_det = ctrl_q[`ASR_CT_ADDR_DET];
    assign irq_en = ctrl_q[`ASR_CT_RX_IE] && ctrl_q[`ASR_CT_PERIPH_IE]
                 && ctrl_q[`ASR_CT_GLOBAL_IE];
    assign last_bit = nine ? `ASR_LAST_BIT9 : `ASR_LAST_BIT8;

    // ----------------------------------------
    // APB slave, one wait state
    // ----------------------------------------
    // Read data is registered, so the answer comes one cycle into access
    assign acc = psel && penable && !pready;
    assign xfer = psel && penable && pready;

    // Read mux over the current state
    always_comb begin
        rd_d = 32'h0;
        if (paddr == `ASR_OFF_CTRL) begin
            rd_d[7:0] = ctrl_q;
        end else if (paddr == `ASR_OFF_STAT) begin
            rd_d[`ASR_ST_READY] = receive_ready_flag;
            rd_d[`ASR_ST_FRAMING_ERROR_FLAG] = framing_error_flag_flag;
            rd_d[`ASR_ST_OVERRUN] = ovr_q;
            rd_d[`ASR_ST_NINTH] = (count_q != 2'h0) && head.ninth;
        end else if (paddr == `ASR_OFF_DATA) begin
            rd_d[7:0] = (count_q != 2'h0) ? head.data : 8'h00;
        end else if (paddr == `ASR_OFF_BAUD) begin
            rd_d[7:0] = baud_q;
        end
    end

    // Answer handshake and data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            pop_ok_q <= 1'b0;
        end else begin
            pready <= acc;
            pslverr <= acc && !is_mapped(paddr);
            if (acc) begin
                prdata <= pwrite ? 32'h0 : rd_d;
                pop_ok_q <= count_q != 2'h0;
            end
        end
    end

    // Software writes; status and data are read only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `ASR_CTRL_RESET;
            baud_q <= `ASR_BAUD_RESET;
        end else if (xfer && pwrite) begin
            if (paddr == `ASR_OFF_CTRL) begin
                ctrl_q <= pwdata[7:0];
            end else if (paddr == `ASR_OFF_BAUD) begin
                baud_q <= pwdata[7:0];
            end
        end
    end

    // A data read pops only if it saw a character when it was answered
    assign pop = xfer && !pwrite && (paddr == `ASR_OFF_DATA) && pop_ok_q
              && (count_q != 2'h0);

    // ----------------------------------------
    // Oversampling tick
    // ----------------------------------------
    // Plain divide by divisor plus one; the speed select only sits in the register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= `ASR_BAUD_RESET;
            tick_q <= 1'b0;
        end else if (!port_en) begin
            div_q <= baud_q;
            tick_q <= 1'b0;
        end else if (div_q == 8'h00) begin
            div_q <= baud_q;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q - 8'h01;
            tick_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Line synchroniser and edge
    // ----------------------------------------
    // Line idles high, so the flops start high to avoid a false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_m_q <= 1'b1;
            rx_s <= 1'b1;
            rx_d_q <= 1'b1;
        end else begin
            rx_m_q <= receive_line_pin;
            rx_s <= rx_m_q;
            rx_d_q <= rx_s;
        end
    end

    assign rx_fall = rx_d_q && !rx_s;

    asr_voter u_asr_voter (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_q),
        .rx_s(rx_s),
        .vote(vote)
    );

    // ----------------------------------------
    // Receive sequencer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
        end else if (!rx_run) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    // No new character while an overrun stands
                    if (rx_fall && !ovr_q) begin
                        st_q <= ST_START;
                    end
                end
                ST_START: begin
                    if (tick_q && cnt_q == `ASR_HALF_BIT) begin
                        st_q <= rx_s ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tick_q && cnt_q == `ASR_BIT_END && bit_q == last_bit) begin
                        st_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (tick_q && cnt_q == `ASR_BIT_END) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Tick counter: restarts at the start centre, then wraps every bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
        end else if (st_q == ST_IDLE) begin
            cnt_q <= 4'h0;
        end else if (st_q == ST_START && tick_q && cnt_q == `ASR_HALF_BIT) begin
            cnt_q <= 4'h0;
        end else if (tick_q) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Bit index and shifter, LSB first, once per bit period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_q <= 4'h0;
            sr_q <= 9'h0;
        end else if (st_q != ST_DATA) begin
            bit_q <= 4'h0;
        end else if (tick_q && cnt_q == `ASR_BIT_END) begin
            bit_q <= bit_q + 4'h1;
            sr_q <= {vote, sr_q[8:1]};
        end
    end

    // ----------------------------------------
    // Character completion and filtering
    // ----------------------------------------
    assign char_done = rx_run && st_q == ST_STOP && tick_q && cnt_q == `ASR_BIT_END;

    // In eight-bit mode the character sits in the top eight bits
    always_comb begin
        in_entry.data = nine ? sr_q[7:0] : sr_q[8:1];
        in_entry.ninth = nine && sr_q[8];
        in_entry.framing_error_flag = !vote;
    end

    // Filtered characters leave no trace at all
    assign keep = !addr_det || in_entry.ninth;
    assign full = (count_q == `ASR_FIFO_FULL) && !pop;
    assign push = char_done && keep && !full;
    assign ovr_set = char_done && keep && full;

    // ----------------------------------------
    // Two-entry FIFO
    // ----------------------------------------
    assign head = mem_q[rd_ptr_q];
    assign framing_error_flag_flag = (count_q != 2'h0) && head.framing_error_flag;

    // Storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `ASR_FIFO_DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (push) begin
            mem_q[wr_ptr_q] <= in_entry;
        end
    end

    // Occupancy; port disable empties it and so clears the error view
    always_comb begin
        if (!port_en) begin
            count_d = 2'h0;
        end else begin
            count_d = count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Pointers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            count_q <= count_d;
            if (!port_en) begin
                rd_ptr_q <= 1'b0;
                wr_ptr_q <= 1'b0;
            end else begin
                if (pop) begin
                    rd_ptr_q <= !rd_ptr_q;
                end
                if (push) begin
                    wr_ptr_q <= !wr_ptr_q;
                end
            end
        end
    end

    // Overrun: a new overrun wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_q <= 1'b0;
        end else if (ovr_set) begin
            ovr_q <= 1'b1;
        end else if (!rx_run) begin
            ovr_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Ready and interrupt track the next occupancy, never software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_ready_flag <= 1'b0;
            rx_irq <= 1'b0;
            receive_pin_input <= 1'b0;
        end else begin
            receive_ready_flag <= count_d != 2'h0;
            rx_irq <= (count_d != 2'h0) && irq_en;
            receive_pin_input <= port_en;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_half_check;
        st_q == ST_START && tick_q && cnt_q == `ASR_HALF_BIT;
    endsequence

    sequence s_full_char;
        char_done && keep && count_q == `ASR_FIFO_FULL && !pop;
    endsequence

    property p_false_start;
        s_half_check ##0 rx_s |=> st_q == ST_IDLE && !ovr_q ##1 !push;
    endproperty
    a_false_start: assert property (p_false_start)
        else $error("false start was not abandoned");

    property p_start_edge;
        $rose(st_q == ST_START) |-> $past(rx_fall) && $past(rx_run);
    endproperty
    a_start_edge: assert property (p_start_edge)
        else $error("character began without a falling edge");

    property p_push_ready;
        push |=> receive_ready_flag && count_q != 2'h0;
    endproperty
    a_push_ready: assert property (p_push_ready)
        else $error("stored character did not raise ready");

    property p_pop_order;
        pop && !push && count_q == `ASR_FIFO_FULL |=> count_q == 2'h1 && receive_ready_flag;
    endproperty
    a_pop_order: assert property (p_pop_order)
        else $error("data read did not advance the fifo");

    property p_stop_framing_error_flag;
        char_done && !vote && push && count_q == 2'h0 |=> framing_error_flag_flag;
    endproperty
    a_stop_framing_error_flag: assert property (p_stop_framing_error_flag)
        else $error("low stop bit not shown as framing error");

    property p_overrun;
        s_full_char |=> ovr_q && count_q == `ASR_FIFO_FULL;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("third character did not set overrun");

    property p_no_accept;
        ovr_q |-> !push && st_q == ST_IDLE;
    endproperty
    a_no_accept: assert property (p_no_accept)
        else $error("character accepted during overrun");

    property p_ovr_clear;
        !rx_run |=> !ovr_q;
    endproperty
    a_ovr_clear: assert property (p_ovr_clear)
        else $error("overrun survived receive disable");

    property p_disable_flush;
        !port_en |=> count_q == 2'h0 && !framing_error_flag_flag && !receive_ready_flag;
    endproperty
    a_disable_flush: assert property (p_disable_flush)
        else $error("port disable did not reset the receiver");

    property p_addr_filter;
        push && addr_det |-> in_entry.ninth;
    endproperty
    a_addr_filter: assert property (p_addr_filter)
        else $error("address filter let a data character through");

    property p_irq_gate;
        rx_irq |-> receive_ready_flag && $past(irq_en);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without ready and all enables");

endmodule // asr_receiver

//--- hdl/asr_voter.sv
`timescale 1ns/100ps

module asr_voter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic rx_s,
    output logic vote
);

    logic [1:0] hist_q;

    // Two of three wins
    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    // Keep the two previous oversampled readings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_q <= 2'h3;
        end else if (tick) begin
            hist_q <= {hist_q[0], rx_s};
        end
    end

    // Vote over the last three ticks ending at the bit centre
    assign vote = maj3(hist_q[1], hist_q[0], rx_s);

endmodule // asr_voter

//--- inc/asr_params.svh
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// ----------------------------------------
// Register map (byte addresses on APB)
// ----------------------------------------
`define ASR_OFF_CTRL 8'h00
`define ASR_OFF_STAT 8'h04
`define ASR_OFF_DATA 8'h08
`define ASR_OFF_BAUD 8'h0c

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ASR_CT_PORT_EN 0
`define ASR_CT_CONTINUOUS_RECEIVE_ENABLE 1
`define ASR_CT_NINE 2
`define ASR_CT_ADDR_DET 3
`define ASR_CT_HIGH_SPEED 4
`define ASR_CT_RX_IE 5
`define ASR_CT_PERIPH_IE 6
`define ASR_CT_GLOBAL_IE 7
`define ASR_CTRL_RESET 8'h00

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ASR_ST_READY 0
`define ASR_ST_FRAMING_ERROR_FLAG 1
`define ASR_ST_OVERRUN 2
`define ASR_ST_NINTH 3

// ----------------------------------------
// Timing and sizes
// ----------------------------------------
`define ASR_BAUD_RESET 8'h00
`define ASR_HALF_BIT 4'h7
`define ASR_BIT_END 4'hf
`define ASR_LAST_BIT8 4'h7
`define ASR_LAST_BIT9 4'h8
`define ASR_FIFO_DEPTH 2
`define ASR_FIFO_FULL 2'h2

`endif

//--- inc/asr_pkg.sv
package asr_pkg;

    // Receive sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP
    } asr_state_e;

    // One FIFO entry: character plus its own status
    typedef struct packed {
        logic framing_error_flag;
        logic ninth;
        logic [7:0] data;
    } asr_entry_s;

endpackage

//--- verification/asr_tx_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// Remote transmitter on the shared line
// ----------------------------------------
module asr_tx_model (
    input logic pclk,
    output logic line
);

    // Line idles high, as if pulled up, between frames
    initial begin
        line = 1'b1;
    end

    // Hold one level for cyc pclk cycles, changed just after an edge
    task automatic hold(input logic v, input int cyc);
        begin
            @(posedge pclk);
            line <= v;
            repeat (cyc - 1) @(posedge pclk);
        end
    endtask

    // One frame, LSB first; a low stop level makes a framing fault on purpose
    task automatic send(input logic [8:0] d, input int nb, input logic stop,
                        input int bit_cyc);
        begin
            hold(1'b0, bit_cyc);
            for (int i = 0; i < nb; i++) begin
                hold(d[i], bit_cyc);
            end
            hold(stop, bit_cyc);
            // Idle gap so a bad stop level never looks like the next start
            hold(1'b1, 2 * bit_cyc);
        end
    endtask

    // Short low pulse, too brief to survive the mid-start recheck
    task automatic glitch();
        begin
            hold(1'b0, 4);
            hold(1'b1, 200);
        end
    endtask
endmodule // asr_tx_model

//--- verification/test_asr_receiver.sv
`timescale 1ns/100ps
`include "asr_params.svh"

module test_asr_receiver;
    localparam logic [31:0] PE = 32'h1 << `ASR_CT_PORT_EN;
    localparam logic [31:0] CR = 32'h1 << `ASR_CT_CONTINUOUS_RECEIVE_ENABLE;
    localparam logic [31:0] NB = 32'h1 << `ASR_CT_NINE;
    localparam logic [31:0] AD = 32'h1 << `ASR_CT_ADDR_DET;
    localparam logic [31:0] RI = 32'h1 << `ASR_CT_RX_IE;
    localparam logic [31:0] GI = 32'h1 << `ASR_CT_GLOBAL_IE;
    localparam logic [31:0] IE3 = RI | GI | (32'h1 << `ASR_CT_PERIPH_IE);
    localparam logic [31:0] RUN = PE | CR | IE3;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rx_line, receive_pin_input, receive_ready_flag, rx_irq;
    int errors, n_compared;

    // ----------------------------------------
    // Clock and instances
    // ----------------------------------------
    // Free-running 125 MHz system clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    asr_receiver u_asr_receiver (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .receive_line_pin(rx_line), .receive_pin_input(receive_pin_input),
        .receive_ready_flag(receive_ready_flag), .rx_irq(rx_irq)
    );
    asr_tx_model u_asr_tx_model (
        .pclk(pclk),
        .line(rx_line)
    );

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    // Single exit point for every outcome, timeouts included
    task automatic close_out();
        begin
            $display("compared %0d mismatches %0d", n_compared, errors);
            if (errors == 0 && n_compared > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        begin
            n_compared++;
            if (got !== exp) begin
                errors++;
                $display("BAD %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask

    // APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        begin
            n = 0;
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            do begin
                @(posedge pclk);
                n++;
            end while (pready !== 1'b1 && n < 20);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (n >= 20) begin
                errors++;
                close_out();
            end
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        begin
            apb(1'b0, a, 32'h0);
            chk(nm, exp, rd);
            chk("pslverr", 32'h0, {31'h0, er});
        end
    endtask

    function automatic logic [31:0] st(input logic r, input logic f, input logic o,
                                       input logic n);
        st = 32'h0;
        st[`ASR_ST_READY] = r;
        st[`ASR_ST_FRAMING_ERROR_FLAG] = f;
        st[`ASR_ST_OVERRUN] = o;
        st[`ASR_ST_NINTH] = n;
    endfunction

    task automatic tx(input logic [8:0] d, input int nb, input logic stop);
        begin
            u_asr_tx_model.send(d, nb, stop, 16);
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    // Reset for 20 cycles, then register and line scenarios in turn
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        n_compared = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rc(`ASR_OFF_CTRL, 32'h0, "ctrl_reset");
        rc(`ASR_OFF_STAT, 32'h0, "stat_reset");
        rc(`ASR_OFF_BAUD, 32'h0, "baud_reset");
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        apb(1'b1, `ASR_OFF_CTRL, PE);
        apb(1'b1, `ASR_OFF_CTRL, PE | IE3);
        apb(1'b1, `ASR_OFF_CTRL, RUN);
        chk("pin_input", 32'h1, {31'h0, receive_pin_input});
        rc(`ASR_OFF_CTRL, RUN, "ctrl_rb");
        // Plain character, interrupt with all enables
        tx(9'h0a5, 8, 1'b1);
        chk("ready", 32'h1, {31'h0, receive_ready_flag});
        chk("irq", 32'h1, {31'h0, rx_irq});
        apb(1'b1, `ASR_OFF_STAT, 32'h0);
        rc(`ASR_OFF_STAT, st(1, 0, 0, 0), "stat_one");
        rc(`ASR_OFF_DATA, 32'h0a5, "data_one");
        rc(`ASR_OFF_STAT, st(0, 0, 0, 0), "stat_empty");
        // Glitch aborts silently, then framing fault per entry
        u_asr_tx_model.glitch();
        rc(`ASR_OFF_STAT, 32'h0, "glitch");
        tx(9'h03c, 8, 1'b0);
        tx(9'h05a, 8, 1'b1);
        rc(`ASR_OFF_STAT, st(1, 1, 0, 0), "framing_error_flag_top");
        rc(`ASR_OFF_DATA, 32'h03c, "data_bad");
        rc(`ASR_OFF_STAT, st(1, 0, 0, 0), "framing_error_flag_next");
        rc(`ASR_OFF_DATA, 32'h05a, "data_good");
        // Missing peripheral enable blocks interrupt; framing fault never raises it
        apb(1'b1, `ASR_OFF_CTRL, PE | CR | RI | GI);
        tx(9'h00f, 8, 1'b0);
        chk("irq_masked", 32'h0, {31'h0, rx_irq});
        apb(1'b1, `ASR_OFF_CTRL, PE | IE3);
        rc(`ASR_OFF_STAT, st(1, 1, 0, 0), "framing_error_flag_continuous_receive_enable_off");
        apb(1'b1, `ASR_OFF_CTRL, 32'h0);
        rc(`ASR_OFF_STAT, 32'h0, "framing_error_flag_port_off");
        chk("pin_released", 32'h0, {31'h0, receive_pin_input});
        // Overrun: third whole character sets it, fourth is dropped
        apb(1'b1, `ASR_OFF_CTRL, RUN);
        tx(9'h011, 8, 1'b0);
        tx(9'h022, 8, 1'b1);
        tx(9'h033, 8, 1'b1);
        rc(`ASR_OFF_STAT, st(1, 1, 1, 0), "overrun");
        tx(9'h044, 8, 1'b1);
        rc(`ASR_OFF_DATA, 32'h011, "ovr_first");
        rc(`ASR_OFF_DATA, 32'h022, "ovr_second");
        rc(`ASR_OFF_STAT, st(0, 0, 1, 0), "ovr_nothing_new");
        apb(1'b1, `ASR_OFF_CTRL, PE | IE3);
        rc(`ASR_OFF_STAT, 32'h0, "ovr_cleared");
        // Nine-bit characters; status read before data
        apb(1'b1, `ASR_OFF_CTRL, RUN | NB);
        tx(9'h1c3, 9, 1'b1);
        tx(9'h055, 9, 1'b1);
        rc(`ASR_OFF_STAT, st(1, 0, 0, 1), "ninth_set");
        rc(`ASR_OFF_DATA, 32'h0c3, "nine_a");
        rc(`ASR_OFF_STAT, st(1, 0, 0, 0), "ninth_clr");
        rc(`ASR_OFF_DATA, 32'h055, "nine_b");
        // Address filter, then kept with address detect off after a match
        apb(1'b1, `ASR_OFF_CTRL, RUN | NB | AD);
        tx(9'h012, 9, 1'b1);
        rc(`ASR_OFF_STAT, 32'h0, "addr_drop");
        tx(9'h1a7, 9, 1'b1);
        rc(`ASR_OFF_STAT, st(1, 0, 0, 1), "addr_keep");
        rc(`ASR_OFF_DATA, 32'h0a7, "addr_data");
        apb(1'b1, `ASR_OFF_CTRL, RUN | NB);
        tx(9'h033, 9, 1'b1);
        rc(`ASR_OFF_DATA, 32'h033, "after_match");
        // Slower baud: tick every second cycle, 32 cycles a bit
        apb(1'b1, `ASR_OFF_BAUD, 32'h1);
        rc(`ASR_OFF_BAUD, 32'h1, "baud_rb");
        u_asr_tx_model.send(9'h096, 8, 1'b1, 32);
        rc(`ASR_OFF_DATA, 32'h096, "slow_data");
        close_out();
    end
endmodule // test_asr_receiver
